// ---- src/emfc_pkg.sv ----
// ****************************************************************
// Shared constants for the error monitor fault counter
// ****************************************************************
package emfc_pkg;

  // Counter width and power-on values; only FC_DEFAULT is also loaded on reload events
  localparam int unsigned CNT_W       = 4;
  localparam logic [3:0]  FC_DEFAULT  = 4'h5;
  localparam logic [3:0]  DEC_DEFAULT = 4'h0;

  // Status register layout
  localparam int unsigned STAT_W       = 8;
  localparam int unsigned FLD_CNT_LSB  = 0;
  localparam int unsigned FLD_CNT_MSB  = 3;
  localparam int unsigned FLD_FAIL     = 4;
  localparam int unsigned FLD_DRV_FAIL = 5;
  localparam int unsigned FLD_RST_FAIL = 6;
  localparam int unsigned FLD_RSVD     = 7;
  localparam logic [7:0]  STAT_RESET   = 8'h05;

  // Device state machine codes, as driven by the surrounding state machine
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_INIT   = 3'b001,
    ST_RESET  = 3'b010,
    ST_DIAG   = 3'b011,
    ST_ACTIVE = 3'b100,
    ST_SAFE   = 3'b101
  } emfc_dev_state_t;

endpackage : emfc_pkg

// ---- src/emfc_sat_cnt.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Saturating up/down counter with synchronous load
// ****************************************************************
module emfc_sat_cnt #(
  parameter int unsigned  W       = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         inc_i,
  input  wire logic         dec_i,
  output logic      [W-1:0] cnt_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire          at_max    = (cnt_q == {W{1'b1}});
  wire          at_min    = (cnt_q == '0);
  // Simultaneous up and down cancel out
  wire          step_up   = inc_i && !dec_i && !at_max;
  wire          step_down = dec_i && !inc_i && !at_min;

  // Load wins, then a single step; ends stick instead of wrapping
  assign cnt_d = load_i    ? load_val_i :
                 step_up   ? W'(cnt_q + 1'b1) :
                 step_down ? W'(cnt_q - 1'b1) : cnt_q;

  // Count register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_q <= RST_VAL;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign cnt_o = cnt_q;

endmodule : emfc_sat_cnt

// ---- src/emfc_fault_status.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Controller error signal monitor: fault counter and status register
// ****************************************************************

// Summary of operation
// - Set flags stay latched until a read, self-test run, mode toggle or RESET entry
// - Read clears flags whose cause is gone
// - Counter writes only in DIAGNOSTIC, unlocked
// - Writes touch only counter bits three-zero
// - Failure counter defaults to five
// - Counter reloads five on listed events
// - Detected error increments the counter
// - Correct response decrements the counter
// - Every error sets general failure flag
// - Drive-off threshold sets both failure flags
// - Drive-off threshold in ACTIVE/DIAGNOSTIC forces SAFE unless reset threshold reached
// - Reset flag set when counter reaches threshold
// - Reset threshold in ACTIVE/DIAGNOSTIC forces RESET
// - Status initialised on reset, read, test, mode
// - Device counter writable only DIAGNOSTIC, unlocked
// - SAFE entry from ACTIVE/DIAGNOSTIC bumps device counter
module emfc_fault_status (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  input  wire emfc_pkg::emfc_dev_state_t dev_state_i,
  input  wire logic                     cfg_lock_i,
  input  wire logic                     errmon_enable_i,
  input  wire logic                     errmon_mode_select_i,
  input  wire logic                     logic_self_test_run_i,
  input  wire logic                     logic_self_test_done_i,
  input  wire logic                     errmon_error_i,
  input  wire logic                     errmon_good_i,
  input  wire logic [3:0]               errmon_drive_off_threshold_i,
  input  wire logic [3:0]               errmon_reset_threshold_i,
  input  wire logic                     read_errmon_status_cmd_i,
  input  wire logic                     write_errmon_counter_cmd_i,
  input  wire logic                     write_device_error_count_cmd_i,
  input  wire logic [7:0]               wr_data_i,
  output logic      [7:0]               errmon_status_o,
  output logic      [3:0]               device_error_counter_o,
  output logic                          enter_safe_req_o,
  output logic                          enter_reset_req_o
);
  import emfc_pkg::*;

  // ****************************************************************
  // Event detection
  // ****************************************************************
  emfc_dev_state_t state_prev_q;
  logic            mode_prev_q;
  logic            enable_prev_q;
  logic            fail_flag_q;
  logic            drv_flag_q;
  logic            rst_flag_q;
  logic [3:0]      fc;
  logic [3:0]      dec_cnt;

  // History of the state and control bits, for entry and toggle edges
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_prev_q  <= ST_OFF;
      mode_prev_q   <= 1'b0;
      enable_prev_q <= 1'b0;
    end else begin
      state_prev_q  <= dev_state_i;
      mode_prev_q   <= errmon_mode_select_i;
      enable_prev_q <= errmon_enable_i;
    end
  end

  // Mode and enable history resets to zero, so a strap-level high start counts as a toggle or rise event
  wire enter_reset  = (dev_state_i == ST_RESET) && (state_prev_q != ST_RESET);
  wire enter_diag   = (dev_state_i == ST_DIAG) && (state_prev_q != ST_DIAG);
  wire mode_toggle  = errmon_mode_select_i != mode_prev_q;
  wire enable_rise  = errmon_enable_i && !enable_prev_q;
  wire prev_act_dia = (state_prev_q == ST_ACTIVE) || (state_prev_q == ST_DIAG);
  wire act_or_diag  = (dev_state_i == ST_ACTIVE) || (dev_state_i == ST_DIAG);
  wire safe_entry   = (dev_state_i == ST_SAFE) && prev_act_dia;

  // ****************************************************************
  // Failure counter
  // ****************************************************************
  // reload event set
  wire reload_evt = enter_reset || enter_diag || logic_self_test_done_i ||
                    mode_toggle || enable_rise;
  wire wr_allowed = (dev_state_i == ST_DIAG) && !cfg_lock_i;
  wire fc_wr_ok   = write_errmon_counter_cmd_i && wr_allowed;
  wire fc_load    = reload_evt || fc_wr_ok;
  // Reload wins over a write in the same cycle
  wire [3:0] fc_load_val = reload_evt ? FC_DEFAULT : wr_data_i[FLD_CNT_MSB:FLD_CNT_LSB];

  emfc_sat_cnt #(
    .W       (CNT_W),
    .RST_VAL (FC_DEFAULT)
  ) u_fail_cnt (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .load_i     (fc_load),
    .load_val_i (fc_load_val),
    .inc_i      (errmon_error_i),
    .dec_i      (errmon_good_i),
    .cnt_o      (fc)
  );

  // ****************************************************************
  // Device error counter
  // ****************************************************************
  // gated write
  wire dec_wr_ok = write_device_error_count_cmd_i && wr_allowed;

  emfc_sat_cnt #(
    .W       (CNT_W),
    .RST_VAL (DEC_DEFAULT)
  ) u_device_error_counter (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .load_i     (dec_wr_ok),
    .load_val_i (wr_data_i[FLD_CNT_MSB:FLD_CNT_LSB]),
    .inc_i      (safe_entry),
    .dec_i      (1'b0),
    .cnt_o      (dec_cnt)
  );

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // threshold compares, on the registered count
  wire drv_cond  = fc >= errmon_drive_off_threshold_i;
  wire rst_cond  = fc >= errmon_reset_threshold_i;
  wire fail_set  = errmon_error_i || drv_cond;
  // clear sources; a cause in the same cycle wins
  wire flag_clr  = read_errmon_status_cmd_i || logic_self_test_run_i ||
                   mode_toggle || enter_reset;
  wire fail_d    = fail_set || (fail_flag_q && !flag_clr);
  wire drv_d     = drv_cond || (drv_flag_q && !flag_clr);
  wire rst_d     = rst_cond || (rst_flag_q && !flag_clr);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fail_flag_q <= STAT_RESET[FLD_FAIL];
      drv_flag_q  <= STAT_RESET[FLD_DRV_FAIL];
      rst_flag_q  <= STAT_RESET[FLD_RST_FAIL];
    end else begin
      fail_flag_q <= fail_d;
      drv_flag_q  <= drv_d;
      rst_flag_q  <= rst_d;
    end
  end

  assign errmon_status_o        = {1'b0, rst_flag_q, drv_flag_q, fail_flag_q, fc};
  assign device_error_counter_o = dec_cnt;

  // ****************************************************************
  // State machine requests
  // ****************************************************************
  // reset request has priority over SAFE
  assign enter_reset_req_o = rst_cond && act_or_diag;
  assign enter_safe_req_o  = drv_cond && act_or_diag && !enter_reset_req_o;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_reload_default;
    reload_evt ##1 (fc == FC_DEFAULT);
  endsequence

  sequence s_safe_bump;
    ##1 (dec_cnt == 4'($past(dec_cnt) + 4'h1));
  endsequence

  property p_flag_hold;
    fail_flag_q && !flag_clr |=> fail_flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("fail flag dropped");

  property p_read_clear;
    read_errmon_status_cmd_i && drv_flag_q && !drv_cond |=> !drv_flag_q;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag kept after read");

  property p_wr_gate;
    write_errmon_counter_cmd_i && !wr_allowed && !reload_evt &&
      !errmon_error_i && !errmon_good_i |=> $stable(fc);
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("locked write moved counter");

  property p_wr_field;
    fc_wr_ok && !reload_evt |=> fc == $past(wr_data_i[FLD_CNT_MSB:FLD_CNT_LSB]);
  endproperty
  a_wr_field: assert property (p_wr_field) else $error("counter write lost");

  property p_reload;
    reload_evt |-> s_reload_default;
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded");

  property p_inc;
    errmon_error_i && !errmon_good_i && !fc_load && fc != 4'hF
      |=> fc == 4'($past(fc) + 4'h1);
  endproperty
  a_inc: assert property (p_inc) else $error("counter missed increment");

  property p_dec;
    errmon_good_i && !errmon_error_i && !fc_load && fc != 4'h0
      |=> fc == 4'($past(fc) - 4'h1);
  endproperty
  a_dec: assert property (p_dec) else $error("counter missed decrement");

  property p_sat;
    errmon_error_i && !fc_load && fc == 4'hF |=> fc == 4'hF;
  endproperty
  a_sat: assert property (p_sat) else $error("counter wrapped");

  property p_fail_set;
    errmon_error_i |=> fail_flag_q;
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("fail flag not set");

  property p_rst_flag;
    rst_cond |=> rst_flag_q;
  endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("reset flag not set");

  property p_safe;
    drv_cond && !rst_cond && act_or_diag |-> enter_safe_req_o;
  endproperty
  a_safe: assert property (p_safe) else $error("no SAFE request");

  property p_reset_req;
    rst_cond && act_or_diag |-> enter_reset_req_o && !enter_safe_req_o;
  endproperty
  a_reset_req: assert property (p_reset_req) else $error("no RESET request");

  property p_dev_cnt;
    safe_entry && !dec_wr_ok && dec_cnt != 4'hF |-> s_safe_bump;
  endproperty
  a_dev_cnt: assert property (p_dev_cnt) else $error("device count not bumped");

  property p_rsvd;
    errmon_status_o[FLD_RSVD] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

endmodule : emfc_fault_status

// ---- test/emfc_ctrl_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Controller model: drives the monitored error signal outcomes
// ****************************************************************
module emfc_ctrl_model (
  input  wire logic sys_clk_i,
  output logic      errmon_error_o,
  output logic      errmon_good_o
);
  // Quiet until told to act
  initial begin
    errmon_error_o = 1'b0;
    errmon_good_o  = 1'b0;
  end

  // One event per high cycle; gap idles between events for a slow controller
  task automatic send(input logic bad, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      errmon_error_o <= bad;
      errmon_good_o  <= !bad;
      repeat (gap) begin
        @(posedge sys_clk_i);
        errmon_error_o <= 1'b0;
        errmon_good_o  <= 1'b0;
      end
    end
    @(posedge sys_clk_i);
    errmon_error_o <= 1'b0;
    errmon_good_o  <= 1'b0;
  endtask : send
endmodule : emfc_ctrl_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Bench top: register access sequences against expected values
// ****************************************************************
module tb_top;
  import emfc_pkg::*;
  logic clk, rst, lock, en, mode, run, done, err, good, rd, wfc, wdev;
  logic [7:0] wdat, stat;
  logic [3:0] dcnt, drv_th, rst_th;
  logic safe_req, rst_req;
  emfc_dev_state_t st;
  int fails, checks;

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  emfc_ctrl_model emfc_ctrl_model_inst (.sys_clk_i(clk), .errmon_error_o(err),
    .errmon_good_o(good));

  emfc_fault_status emfc_fault_status_inst (.sys_clk_i(clk), .rst_i(rst),
    .dev_state_i(st), .cfg_lock_i(lock), .errmon_enable_i(en),
    .errmon_mode_select_i(mode), .logic_self_test_run_i(run),
    .logic_self_test_done_i(done), .errmon_error_i(err), .errmon_good_i(good),
    .errmon_drive_off_threshold_i(drv_th), .errmon_reset_threshold_i(rst_th),
    .read_errmon_status_cmd_i(rd), .write_errmon_counter_cmd_i(wfc),
    .write_device_error_count_cmd_i(wdev), .wr_data_i(wdat),
    .errmon_status_o(stat), .device_error_counter_o(dcnt),
    .enter_safe_req_o(safe_req), .enter_reset_req_o(rst_req));

  // ****************************************************************
  // Access and compare tasks
  // ****************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1

  // Status byte is judged in the read cycle, before the clear lands
  task automatic rd_chk(input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    #1 chk8(stat, exp, "status read");
    @(posedge clk);
    rd <= 1'b0;
    step(1);
  endtask : rd_chk

  task automatic wr(input logic dev, input logic [7:0] d);
    @(posedge clk);
    wfc  <= !dev;
    wdev <= dev;
    wdat <= d;
    @(posedge clk);
    wfc  <= 1'b0;
    wdev <= 1'b0;
    step(2);
  endtask : wr

  task automatic go(input emfc_dev_state_t s);
    @(posedge clk);
    st <= s;
    step(3);
  endtask : go

  task automatic ev(input logic bad, input int n);
    emfc_ctrl_model_inst.send(bad, n, 0);
    step(2);
  endtask : ev

  task automatic tend(input string s);
    $display("test %s finished, %0d checks %0d fails", s, checks, fails);
  endtask : tend

  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // Watchdog, far beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    {rst, lock, en, mode, run, done, rd, wfc, wdev} = 9'h100;
    wdat   = 8'h00;
    drv_th = 4'h8;
    rst_th = 4'hA;
    st = ST_ACTIVE;
    // Reset held over 20 rising edges, released on an edge
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    step(2);
    chk8(stat, 8'h05, "reset status");
    chk8({4'h0, dcnt}, 8'h00, "reset device count");
    tend("reset");
    emfc_ctrl_model_inst.send(1'b1, 1, 0);
    step(6);
    chk8(stat, 8'h16, "error latched");
    rd_chk(8'h16);
    rd_chk(8'h06);
    ev(1'b0, 1);
    chk8(stat, 8'h05, "good response");
    tend("count");
    ev(1'b1, 3);
    chk8(stat, 8'h38, "drive-off level");
    chk1(safe_req, 1'b1, "safe request");
    rd_chk(8'h38);
    ev(1'b0, 3);
    chk1(safe_req, 1'b0, "safe released");
    rd_chk(8'h35);
    rd_chk(8'h05);
    tend("drive-off");
    ev(1'b1, 5);
    chk8(stat, 8'h7A, "reset level");
    chk1(rst_req, 1'b1, "reset request");
    chk1(safe_req, 1'b0, "reset wins");
    go(ST_SAFE);
    chk1(rst_req, 1'b0, "no request in safe");
    chk8({4'h0, dcnt}, 8'h01, "safe entry bump");
    ev(1'b1, 7);
    chk8(stat, 8'h7F, "top saturation");
    ev(1'b0, 17);
    chk8(stat, 8'h70, "bottom saturation");
    rd_chk(8'h70);
    rd_chk(8'h00);
    tend("reset and saturation");
    go(ST_ACTIVE);
    wr(1'b0, 8'hF3);
    chk8(stat, 8'h00, "write outside diag");
    go(ST_DIAG);
    chk8(stat, 8'h05, "diag entry reload");
    @(posedge clk);
    lock <= 1'b1;
    wr(1'b0, 8'hF3);
    chk8(stat, 8'h05, "locked write");
    wr(1'b1, 8'hF7);
    chk8({4'h0, dcnt}, 8'h01, "locked device write");
    @(posedge clk);
    lock <= 1'b0;
    wr(1'b0, 8'hF3);
    chk8(stat, 8'h03, "counter write");
    wr(1'b1, 8'hF7);
    chk8({4'h0, dcnt}, 8'h07, "device write");
    tend("writes");
    ev(1'b1, 1);
    @(posedge clk);
    mode <= 1'b1;
    step(3);
    chk8(stat, 8'h05, "mode toggle");
    wr(1'b0, 8'hF3);
    @(posedge clk);
    en <= 1'b1;
    step(3);
    chk8(stat, 8'h05, "enable rise");
    wr(1'b0, 8'hF3);
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    step(2);
    chk8(stat, 8'h05, "self-test done");
    ev(1'b1, 1);
    @(posedge clk);
    run <= 1'b1;
    @(posedge clk);
    run <= 1'b0;
    step(2);
    chk8(stat, 8'h06, "self-test run");
    // Thresholds moved under a standing count, in DIAGNOSTIC
    @(posedge clk);
    drv_th <= 4'h6;
    step(2);
    chk8(stat, 8'h36, "drive-off threshold moved");
    chk1(safe_req, 1'b1, "safe request in diag");
    @(posedge clk);
    rst_th <= 4'h6;
    step(2);
    chk8(stat, 8'h76, "reset threshold moved");
    chk1(rst_req, 1'b1, "reset request in diag");
    chk1(safe_req, 1'b0, "reset wins in diag");
    @(posedge clk);
    drv_th <= 4'h8;
    rst_th <= 4'hA;
    go(ST_RESET);
    chk8(stat, 8'h05, "reset entry");
    tend("reloads");
    give_verdict();
  end
endmodule : tb_top
